// File: logic/astx_params.svh
// offsets, reset values and timing counts of the serial transceiver
// ****************************************************************
// ****************************************************************
`ifndef ASTX_PARAMS_SVH
`define ASTX_PARAMS_SVH
`define ASTX_ADDR_W       12
`define ASTX_OFS_CTRL_A   12'h f95
`define ASTX_OFS_CTRL_B   12'h f96
`define ASTX_OFS_STATUS   12'h f95
`define ASTX_OFS_HOLDING  12'h f97
`define ASTX_CTRL_A_RST   8'h 00
`define ASTX_CTRL_B_RST   3'h 0
`define ASTX_DIV_0        9'd13
`define ASTX_DIV_1        9'd26
`define ASTX_DIV_2        9'd52
`define ASTX_DIV_3        9'd104
`define ASTX_DIV_4        9'd208
`define ASTX_DIV_5        9'd416
`define ASTX_DIV_7        9'd96
`define ASTX_RATE_TIMER   3'h 6
`define ASTX_FILT_1       7'd31
`define ASTX_FILT_2       7'd63
`define ASTX_FILT_3       7'd127
`define ASTX_TICK_LAST    4'h f
`define ASTX_TICK_S0      4'h 7
`define ASTX_TICK_S1      4'h 8
`define ASTX_TICK_S2      4'h 9
`define ASTX_DATA_BITS    4'd8
`define ASTX_FRAME_BASE   4'd10
`endif

// File: logic/astx_pkg.sv
// types shared by the serial transceiver
package astx_pkg;
	// control word a, bit 7 down to bit 0
	typedef struct packed {
		logic       tx_enable;
		logic       rx_enable;
		logic       tx_stop_len;
		logic       parity_even;
		logic       parity_on;
		logic [2:0] rate_select;
	} astx_ctrl_a_t;
	// status word, low two bits read as zero
	typedef struct packed {
		logic       parity_error_flag;
		logic       framing_error_flag;
		logic       overrun_flag;
		logic       rx_full_flag;
		logic       tx_done_flag;
		logic       tx_empty_flag;
		logic [1:0] unused;
	} astx_status_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} astx_rx_state_t;
endpackage

// File: logic/astx_top.sv
// full-duplex asynchronous serial transceiver with register port
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "astx_params.svh"
module astx_top
	import astx_pkg::*;
(
	input  wire logic                    CORE_CLK,
	input  wire logic                    RST_N,
	input  wire logic [`ASTX_ADDR_W-1:0] ADDR,
	input  wire logic [7:0]              WR_DATA,
	input  wire logic                    WR_EN,
	input  wire logic                    RD_EN,
	output logic      [7:0]              RD_DATA,
	input  wire logic                    AUX_TIMER_TICK,
	input  wire logic                    RX_PIN,
	output logic                         TX_PIN,
	output logic                         TX_IRQ,
	output logic                         RX_IRQ
);
	// ****************************************************************
	// register file
	// ****************************************************************
	astx_ctrl_a_t   ctrl_a_q;
	logic [2:0]     ctrl_b_q;
	astx_status_t   status;
	logic           parity_error_flag_q, framing_error_flag_q, overrun_flag_q, rx_full_flag_q, tx_done_flag_q, tx_empty_flag_q;
	logic [7:0]     rx_buf_q, tx_hold_q, rd_q;
	logic           st_armed_q, tx_armed_q, overrun_flag_snap_q;
	logic           rd_status, rd_hold, wr_hold, wr_hold_ok, rx_read_ok;

	assign rd_status  = RD_EN && ADDR == `ASTX_OFS_STATUS;
	assign rd_hold    = RD_EN && ADDR == `ASTX_OFS_HOLDING;
	assign wr_hold    = WR_EN && ADDR == `ASTX_OFS_HOLDING;
	assign wr_hold_ok = wr_hold && tx_armed_q;
	assign rx_read_ok = rd_hold && st_armed_q;
	assign status = '{parity_error_flag_q, framing_error_flag_q, overrun_flag_q, rx_full_flag_q, tx_done_flag_q, tx_empty_flag_q, 2'b00};

	// control writes; rate changes mid-frame are left to software
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			ctrl_a_q <= `ASTX_CTRL_A_RST;
			ctrl_b_q <= `ASTX_CTRL_B_RST;
		end
		else if (WR_EN && ADDR == `ASTX_OFS_CTRL_A)
			ctrl_a_q <= WR_DATA;
		else if (WR_EN && ADDR == `ASTX_OFS_CTRL_B)
			ctrl_b_q <= WR_DATA[2:0];

	// read data one cycle after the strobe, unmapped reads as zero
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
			rd_q <= 8'h00;
		else if (rd_status)
			rd_q <= status;
		else if (rd_hold)
			rd_q <= rx_buf_q;
		else
			rd_q <= 8'h00;
	assign RD_DATA = rd_q;

	// status read arms both buffer accesses; overrun state is snapshot
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			st_armed_q  <= 1'b0;
			tx_armed_q  <= 1'b0;
			overrun_flag_snap_q <= 1'b0;
		end
		else if (rd_status)
		begin
			st_armed_q  <= 1'b1;
			tx_armed_q  <= 1'b1;
			overrun_flag_snap_q <= overrun_flag_q;
		end
		else
		begin
			if (rd_hold)
				st_armed_q <= 1'b0;
			if (wr_hold)
				tx_armed_q <= 1'b0;
		end

	// ****************************************************************
	// rate generator
	// ****************************************************************
	function automatic logic [8:0] rate_div(input logic [2:0] code);
		case (code)
			3'h0: rate_div = `ASTX_DIV_0;
			3'h1: rate_div = `ASTX_DIV_1;
			3'h2: rate_div = `ASTX_DIV_2;
			3'h3: rate_div = `ASTX_DIV_3;
			3'h4: rate_div = `ASTX_DIV_4;
			3'h5: rate_div = `ASTX_DIV_5;
			3'h7: rate_div = `ASTX_DIV_7;
			default: rate_div = 9'd1;
		endcase
	endfunction

	logic [8:0] div_q;
	logic       tick_q;
	// tick is sixteen per bit; timer mode passes the timer match through
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			div_q  <= 9'd0;
			tick_q <= 1'b0;
		end
		else if (ctrl_a_q.rate_select == `ASTX_RATE_TIMER)
		begin
			div_q  <= 9'd0;
			tick_q <= AUX_TIMER_TICK;
		end
		else if (div_q >= rate_div(ctrl_a_q.rate_select) - 9'd1)
		begin
			div_q  <= 9'd0;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q  <= div_q + 9'd1;
			tick_q <= 1'b0;
		end

	// ****************************************************************
	// glitch filter
	// ****************************************************************
	logic [6:0] filt_cnt_q, filt_lim;
	logic       rx_filt_q;
	always_comb
		case (ctrl_b_q[2:1])
			2'h1: filt_lim = `ASTX_FILT_1;
			2'h2: filt_lim = `ASTX_FILT_2;
			2'h3: filt_lim = `ASTX_FILT_3;
			default: filt_lim = 7'd0;
		endcase
	// a level must hold filt_lim clocks before it is believed
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			rx_filt_q  <= 1'b1;
			filt_cnt_q <= 7'd0;
		end
		else if (RX_PIN == rx_filt_q)
			filt_cnt_q <= 7'd0;
		else if (filt_cnt_q + 7'd1 >= filt_lim)
		begin
			rx_filt_q  <= RX_PIN;
			filt_cnt_q <= 7'd0;
		end
		else
			filt_cnt_q <= filt_cnt_q + 7'd1;

	// ****************************************************************
	// receiver
	// ****************************************************************
	astx_rx_state_t rx_state_q;
	logic [3:0]     rx_tick_q, rx_cnt_q;
	logic [1:0]     samp_q;
	logic [7:0]     rx_sh_q;
	logic           rx_par_q, rx_framing_error_flag_q, rx_done, maj, bit_end, rx_irq_q;

	// two of three samples decide the bit; tick 9 is read live from the line
	assign maj     = (samp_q[1] & samp_q[0]) | (samp_q[1] & rx_filt_q)
		| (samp_q[0] & rx_filt_q);
	assign bit_end = tick_q && rx_tick_q == `ASTX_TICK_S2;
	assign rx_done = bit_end && rx_state_q == RX_STOP && rx_cnt_q == 4'd0;

	// samples kept at ticks 7 and 8
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
			samp_q <= 2'h3;
		else if (tick_q && (rx_tick_q == `ASTX_TICK_S0 || rx_tick_q == `ASTX_TICK_S1))
			samp_q <= {samp_q[0], rx_filt_q};

	// bit-position counter, zero at the detected start edge
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
			rx_tick_q <= 4'h0;
		else if (rx_state_q == RX_IDLE)
			rx_tick_q <= 4'h0;
		else if (tick_q)
			rx_tick_q <= rx_tick_q + 4'h1;

	// frame walker; decisions land at tick 9 using the third sample
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			rx_state_q <= RX_IDLE;
			rx_cnt_q   <= 4'd0;
			rx_sh_q    <= 8'h00;
			rx_par_q   <= 1'b0;
			rx_framing_error_flag_q  <= 1'b0;
		end
		else
			unique case (rx_state_q)
				RX_IDLE:
					// enable checked only here, so a disable waits for frame end
					if (tick_q && !rx_filt_q && ctrl_a_q.rx_enable && !overrun_flag_q)
					begin
						rx_state_q <= RX_START;
						rx_framing_error_flag_q  <= 1'b0;
					end
				RX_START:
					if (bit_end)
					begin
						rx_cnt_q   <= `ASTX_DATA_BITS - 4'd1;
						rx_state_q <= maj ? RX_IDLE : RX_DATA; // false start
					end
				RX_DATA:
					if (bit_end)
					begin
						rx_sh_q  <= {maj, rx_sh_q[7:1]};
						rx_cnt_q <= rx_cnt_q - 4'd1;
						if (rx_cnt_q == 4'd0)
							rx_state_q <= ctrl_a_q.parity_on ? RX_PARITY : RX_STOP;
						if (rx_cnt_q == 4'd0)
							rx_cnt_q <= {3'd0, ctrl_b_q[0]};
					end
				RX_PARITY:
					if (bit_end)
					begin
						rx_par_q   <= maj;
						rx_state_q <= RX_STOP;
					end
				RX_STOP:
					if (bit_end)
					begin
						if (!maj)
							rx_framing_error_flag_q <= 1'b1;
						rx_cnt_q <= rx_cnt_q - 4'd1;
						if (rx_cnt_q == 4'd0)
							rx_state_q <= RX_IDLE;
					end
			endcase

	// alignment: bit_end fires at tick 9, then the walker idles through to 15
	logic rx_parity_error_flag;
	assign rx_parity_error_flag = ctrl_a_q.parity_on
		&& (rx_par_q != ((^rx_sh_q) ^ !ctrl_a_q.parity_even));

	// flags: a hardware set in the same cycle wins over the read clear
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			parity_error_flag_q   <= 1'b0;
			framing_error_flag_q   <= 1'b0;
			overrun_flag_q   <= 1'b0;
			rx_full_flag_q   <= 1'b0;
			rx_buf_q <= 8'h00;
			rx_irq_q <= 1'b0;
		end
		else
		begin
			rx_irq_q <= 1'b0;
			if (rx_read_ok)
			begin
				parity_error_flag_q <= 1'b0;
				framing_error_flag_q <= 1'b0;
				rx_full_flag_q <= 1'b0;
				if (overrun_flag_snap_q)
					overrun_flag_q <= 1'b0;
			end
			if (rx_done && rx_full_flag_q && !rx_read_ok)
				overrun_flag_q <= 1'b1;
			else if (rx_done)
			begin
				rx_buf_q <= rx_sh_q;
				rx_full_flag_q   <= 1'b1;
				parity_error_flag_q   <= rx_parity_error_flag;
				framing_error_flag_q   <= rx_framing_error_flag_q || !maj;
				rx_irq_q <= 1'b1;
			end
		end
	assign RX_IRQ = rx_irq_q;

	// ****************************************************************
	// transmitter
	// ****************************************************************
	logic [11:0] tx_sh_q;
	logic [3:0]  tx_left_q, tx_sub_q;
	logic        tx_busy_q, tx_full_q, tx_pin_q, tx_irq_q, tx_start, tx_shift, tx_last;

	assign tx_start = !tx_busy_q && tx_full_q && ctrl_a_q.tx_enable;
	assign tx_shift = tx_busy_q && tick_q && tx_sub_q == `ASTX_TICK_LAST;
	assign tx_last  = tx_shift && tx_left_q == 4'd1;

	// holding buffer: only a write after a status read counts
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			tx_hold_q <= 8'h00;
			tx_full_q <= 1'b0;
		end
		else if (wr_hold_ok)
		begin
			tx_hold_q <= WR_DATA;
			tx_full_q <= 1'b1;
		end
		else if (tx_start)
			tx_full_q <= 1'b0;

	// shifter: stops, parity, data, start, sent from bit 0
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			tx_sh_q   <= 12'hfff;
			tx_left_q <= 4'd0;
			tx_sub_q  <= 4'h0;
			tx_busy_q <= 1'b0;
		end
		else if (tx_start)
		begin
			tx_sh_q <= {2'b11, ctrl_a_q.parity_on
				? ((^tx_hold_q) ^ !ctrl_a_q.parity_even) : 1'b1,
				tx_hold_q, 1'b0};
			tx_left_q <= `ASTX_FRAME_BASE + {3'd0, ctrl_a_q.parity_on}
				+ {3'd0, ctrl_a_q.tx_stop_len};
			tx_sub_q  <= 4'h0;
			tx_busy_q <= 1'b1;
		end
		else if (tx_busy_q && tick_q)
		begin
			tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_shift)
			begin
				tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
				tx_left_q <= tx_left_q - 4'd1;
				if (tx_last)
					tx_busy_q <= 1'b0;
			end
		end

	// line level, high whenever no frame is in flight
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
			tx_pin_q <= 1'b1;
		else if (tx_start)
			tx_pin_q <= 1'b0;
		else if (tx_last)
			tx_pin_q <= 1'b1;
		else if (tx_shift)
			tx_pin_q <= tx_sh_q[1];
	assign TX_PIN = tx_pin_q;

	// empty and end flags, interrupt on each start
	always_ff @(posedge CORE_CLK or negedge RST_N)
		if (!RST_N)
		begin
			tx_empty_flag_q   <= 1'b1;
			tx_done_flag_q   <= 1'b1;
			tx_irq_q <= 1'b0;
		end
		else
		begin
			tx_irq_q <= tx_start;
			if (tx_start)
			begin
				tx_empty_flag_q <= 1'b1;
				tx_done_flag_q <= 1'b0;
			end
			else if (wr_hold_ok)
				tx_empty_flag_q <= 1'b0;
			if (tx_last && !tx_full_q)
				tx_done_flag_q <= 1'b1;
		end
	assign TX_IRQ = tx_irq_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	AST_TX_IDLE_HIGH: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		!tx_busy_q && !$past(tx_busy_q) |-> TX_PIN)
		else $error("tx pin low while idle");
	AST_TX_WRITE_CLEARS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		wr_hold_ok && !tx_start |=> !tx_empty_flag_q && tx_full_q)
		else $error("holding write did not clear empty flag");
	AST_TX_START_IRQ: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		$rose(tx_busy_q) |-> tx_empty_flag_q && TX_IRQ && !TX_PIN)
		else $error("start without empty flag or irq");
	AST_TX_NO_ARM: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		wr_hold && !tx_armed_q && !tx_full_q && !tx_busy_q |=> !tx_busy_q && tx_empty_flag_q)
		else $error("unarmed write started transmit");
	AST_RX_LOAD: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		rx_done && !rx_full_flag_q |=> rx_full_flag_q && RX_IRQ && rx_buf_q == $past(rx_sh_q))
		else $error("receive load missing");
	AST_RX_OVERRUN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		rx_done && rx_full_flag_q && !rx_read_ok |=> overrun_flag_q && $stable(rx_buf_q) && !RX_IRQ)
		else $error("overrun handling wrong");
	AST_RX_HOLD_OFF: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		overrun_flag_q && rx_state_q == RX_IDLE |=> rx_state_q == RX_IDLE)
		else $error("receiver started during overrun");
	AST_RX_CLEAR: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		rx_read_ok && !rx_done |=> !rx_full_flag_q && !parity_error_flag_q && !framing_error_flag_q)
		else $error("buffer read did not clear flags");
	AST_TX_END: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		tx_last && !tx_full_q && !wr_hold_ok |=> tx_done_flag_q ##1 tx_done_flag_q)
		else $error("end flag not set");
endmodule

// File: verif/astx_remote.sv
// remote serial device model: frame sender and frame catcher on the line
`timescale 1ns/1ps
module astx_remote
#(
	parameter int BIT_CYC = 208
)
(
	input  wire logic clk,
	input  wire logic line_in,
	output logic      line_out
);
	// idle line is high between frames
	initial line_out = 1'b1;

	// one bit held for a whole bit time
	task automatic put(input logic b);
		line_out <= b;
		repeat (BIT_CYC) @(posedge clk);
	endtask

	// low start, data lsb first, optional parity, high stops
	task automatic send(input logic [7:0] d, input logic par, input logic even,
		input logic two, input logic bad_par, input logic bad_stop);
		@(posedge clk);
		put(1'b0);
		for (int i = 0; i < 8; i++)
			put(d[i]);
		if (par)
			put(^d ^ ~even ^ bad_par); // broken only when a case asks
		if (two)
			put(1'b1);
		put(~bad_stop);
		put(1'b1);
	endtask

	// short low pulse, shorter than a bit, for the input filter
	task automatic pulse(input int len);
		@(posedge clk);
		line_out <= 1'b0;
		repeat (len) @(posedge clk);
		line_out <= 1'b1;
	endtask

	// mid-bit samples from the start edge; gives up if no start comes
	task automatic catch_frame(output logic [12:0] bits);
		int n;
		n = 0;
		while (line_in !== 1'b0 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		repeat (BIT_CYC / 2) @(posedge clk);
		for (int i = 0; i < 13; i++)
		begin
			bits[i] = line_in;
			repeat (BIT_CYC) @(posedge clk);
		end
	endtask
endmodule

// File: verif/tb_top.sv
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] ctrl;
		logic       two;
		logic [1:0] bad;
		logic [7:0] stat;
	} astx_row_t;

	logic        core_clk = 1'b0;
	logic        rst_n    = 1'b0;
	logic [11:0] addr     = 12'h000;
	logic [7:0]  wr_data  = 8'h00;
	logic        wr_en    = 1'b0;
	logic        rd_en    = 1'b0;
	logic        aux_tick = 1'b0;
	logic [7:0]  rd_data;
	logic        rx_pin;
	logic        tx_pin;
	logic        tx_irq;
	logic        rx_irq;
	logic [12:0] bits;
	logic [12:0] exp_bits;
	logic [12:0] mask;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          aux_cnt = 0;
	int          ntx = 0;
	int          nrx = 0;
	int          n;
	int          lo;
	int          n0;
	// data, ctrl a, two stops, {bad stop, bad parity}, status after receive
	astx_row_t   rows [5] = '{'{8'h35, 8'hc0, 1'b0, 2'h0, 8'h1c},
		'{8'hc3, 8'hf8, 1'b1, 2'h0, 8'h1c}, '{8'h80, 8'hc8, 1'b0, 2'h0, 8'h1c},
		'{8'h6e, 8'hd8, 1'b0, 2'h1, 8'h9c}, '{8'h0f, 8'he0, 1'b1, 2'h2, 8'h5c}};
	// one bit length in clocks for each rate code; code 6 follows the timer
	logic [15:0] rates [8] = '{16'd208, 16'd416, 16'd832, 16'd1664, 16'd3328, 16'd6656,
		16'd80, 16'd1536};

	always #4 core_clk = ~core_clk;

	astx_top DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data),
		.WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .AUX_TIMER_TICK(aux_tick),
		.RX_PIN(rx_pin), .TX_PIN(tx_pin), .TX_IRQ(tx_irq), .RX_IRQ(rx_irq));

	astx_remote #(.BIT_CYC(208)) u_rem (.clk(core_clk), .line_in(tx_pin), .line_out(rx_pin));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic give_verdict();
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 check({8'h00, rd_data}, {8'h00, e});
	endtask

	// timer pulse every fifth clock, pulse counters, hang limit
	always @(posedge core_clk)
	begin
		aux_cnt <= (aux_cnt == 4) ? 0 : aux_cnt + 1;
		aux_tick <= (aux_cnt == 4);
		cyc <= cyc + 1;
		if (tx_irq === 1'b1)
			ntx <= ntx + 1;
		if (rx_irq === 1'b1)
			nrx <= nrx + 1;
		if (cyc == 90000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		wr(12'hf95, 8'hc0);
		wr(12'hf97, 8'h99); // no status read first, so it must be dropped
		repeat (300) @(posedge core_clk);
		check({15'h0, tx_pin}, 16'h1);
		rdc(12'hf95, 8'h0c);
		rdc(12'hf97, 8'h00);
		rdc(12'h000, 8'h00);
		check(16'(ntx), 16'h0);
		foreach (rows[r])
		begin
			wr(12'hf95, rows[r].ctrl);
			wr(12'hf96, {7'h00, rows[r].two});
			n0 = ntx;
			fork
				u_rem.catch_frame(bits);
				begin
					rdc(12'hf95, 8'h0c);
					wr(12'hf97, rows[r].data);
					repeat (3) @(posedge core_clk);
					rdc(12'hf95, 8'h04);
					wr(12'hf97, ~rows[r].data);
					rdc(12'hf95, 8'h00);
				end
			join
			// first frame plus the start of the queued one
			exp_bits = 13'h1fff;
			exp_bits[0] = 1'b0;
			exp_bits[8:1] = rows[r].data;
			if (rows[r].ctrl[3])
				exp_bits[9] = ^rows[r].data ^ ~rows[r].ctrl[4];
			n = 10 + rows[r].ctrl[3] + rows[r].ctrl[5];
			exp_bits[n] = 1'b0;
			mask = 13'h1fff >> (12 - n);
			check({3'h0, bits & mask}, {3'h0, exp_bits & mask});
			repeat (12 * 208) @(posedge core_clk);
			rdc(12'hf95, 8'h0c);
			check(16'(ntx - n0), 16'h2);
			n0 = nrx;
			u_rem.send(rows[r].data, rows[r].ctrl[3], rows[r].ctrl[4], rows[r].two,
				rows[r].bad[0], rows[r].bad[1]);
			rdc(12'hf95, rows[r].stat);
			rdc(12'hf97, rows[r].data);
			rdc(12'hf95, 8'h0c);
			check(16'(nrx - n0), 16'h1);
		end
		// overrun after the status read, then refusal while it stands
		wr(12'hf95, 8'h40);
		wr(12'hf96, 8'h00);
		u_rem.send(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rdc(12'hf95, 8'h1c);
		u_rem.send(8'ha5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rdc(12'hf97, 8'h5a);
		rdc(12'hf95, 8'h2c);
		u_rem.send(8'h33, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rdc(12'hf95, 8'h2c);
		rdc(12'hf97, 8'h5a);
		rdc(12'hf95, 8'h0c);
		u_rem.send(8'h77, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rdc(12'hf95, 8'h1c);
		rdc(12'hf97, 8'h77);
		// filter at 127 clocks: a 120 clock low pulse would otherwise frame 0xff
		wr(12'hf96, 8'h06);
		u_rem.pulse(120);
		repeat (2400) @(posedge core_clk);
		rdc(12'hf95, 8'h0c);
		u_rem.send(8'h3c, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rdc(12'hf95, 8'h1c);
		rdc(12'hf97, 8'h3c);
		// first data bit length for every rate code; the start bit may be
		// shortened by the free-running tick phase, so the shifted bit is timed
		foreach (rates[k])
		begin
			rst_n <= 1'b0; // enables cleared before the rate changes
			repeat (2) @(posedge core_clk);
			rst_n <= 1'b1;
			wr(12'hf95, {5'h10, 3'(k)});
			rdc(12'hf95, 8'h0c);
			wr(12'hf97, 8'h01);
			n = 0;
			lo = 0;
			while (tx_pin !== 1'b0 && n < 8000)
			begin
				@(posedge core_clk);
				n++;
			end
			while (tx_pin === 1'b0 && lo < 8000)
			begin
				@(posedge core_clk);
				lo++;
			end
			lo = 0;
			while (tx_pin === 1'b1 && lo < 8000)
			begin
				@(posedge core_clk);
				lo++;
			end
			check(16'(lo), rates[k]);
		end
		give_verdict();
	end
endmodule
